// *** hdl/iod_regs.svh ***
// register offsets, field positions and reset values of the or-decoder
`ifndef IOD_REGS_SVH
`define IOD_REGS_SVH
`define IOD_OFF_INSTR   8'h00
`define IOD_OFF_STATUS  8'h04
`define IOD_OFF_CCB     8'h08
`define IOD_OFF_EAOP    8'h0c
`define IOD_OFF_RESULT  8'h10
`define IOD_OFF_DREG    8'h20
`define IOD_DREG_LAST   8'h3c
`define IOD_ST_BUSY     0
`define IOD_ST_ILLEGAL  1
`define IOD_ST_DONE     2
`define IOD_CCB_X       4
`define IOD_CCB_N       3
`define IOD_CCB_Z       2
`define IOD_CCB_V       1
`define IOD_CCB_C       0
`define IOD_CCB_RST     5'h00
`define IOD_OR_GROUP    4'h8
`define IOD_CCB_OPCODE  16'h003c
`define IOD_MODE_DREG   3'h0
`define IOD_MODE_AREG   3'h1
`define IOD_MODE_IND    3'h2
`define IOD_MODE_EXT    3'h7
`define IOD_REG_ABSL    3'h1
`define IOD_REG_IMM     3'h4
`endif

// *** hdl/iod_pkg.sv ***
// types shared by the or-decoder
package iod_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEC  = 3'b001,
    ST_EXT1 = 3'b010,
    ST_EXT2 = 3'b011,
    ST_EXEC = 3'b100
  } iod_state_t;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } iod_size_t;
endpackage

// *** hdl/iod_top.sv ***
// apb-fed decode and execute of the inclusive-or instruction family
`timescale 1ns/1ps
`include "iod_regs.svh"
module iod_top (
  input  wire logic        pclk,     // processor clock
  input  wire logic        presetn,  // async reset, active low
  input  wire logic [7:0]  paddr,    // apb byte address
  input  wire logic        psel,     // apb select
  input  wire logic        penable,  // apb access phase
  input  wire logic        pwrite,   // apb direction
  input  wire logic [31:0] pwdata,   // apb write data
  output logic      [31:0] prdata,   // apb read data
  output logic             pready,   // apb ready
  output logic             pslverr   // apb error, unmapped address
);
  iod_pkg::iod_state_t state_reg, state_next;
  logic [15:0] op_reg;
  logic [31:0] imm_reg;
  logic [31:0] eaop_reg;
  logic [31:0] result_reg;
  logic [4:0]  ccb_reg;
  logic        illegal_reg, done_reg;
  logic [31:0] dreg_reg [8];

  // apb phase decode; transfer completes where pready is seen high
  wire        acc_first = psel & penable & ~pready;
  wire        acc_done  = psel & penable & pready;
  wire        bus_wr    = acc_done & pwrite;
  wire        hit_dreg  = (paddr >= `IOD_OFF_DREG) && (paddr <= `IOD_DREG_LAST)
                          && (paddr[1:0] == 2'b00);
  wire        hit_fixed = (paddr == `IOD_OFF_INSTR) || (paddr == `IOD_OFF_STATUS)
                          || (paddr == `IOD_OFF_CCB) || (paddr == `IOD_OFF_EAOP)
                          || (paddr == `IOD_OFF_RESULT);
  wire        hit       = hit_dreg | hit_fixed;
  wire [2:0]  bus_didx  = paddr[4:2];
  wire        wr_instr  = bus_wr & (paddr == `IOD_OFF_INSTR);
  wire        wr_status = bus_wr & (paddr == `IOD_OFF_STATUS);
  wire        wr_ccb    = bus_wr & (paddr == `IOD_OFF_CCB);
  wire        wr_eaop   = bus_wr & (paddr == `IOD_OFF_EAOP);
  wire        wr_dreg   = bus_wr & hit_dreg;
  wire [15:0] word_in   = pwdata[15:0];

  // opcode fields
  wire [2:0]  reg_sel = op_reg[11:9];
  wire [2:0]  opm     = op_reg[8:6];
  wire [2:0]  ea_mode = op_reg[5:3];
  wire [2:0]  ea_reg  = op_reg[2:0];

  // instruction class recognition
  wire is_ccb = (op_reg == `IOD_CCB_OPCODE);
  wire is_or  = (op_reg[15:12] == `IOD_OR_GROUP) && (opm != 3'b011)
                && (opm != 3'b111);
  wire is_imm = (op_reg[15:8] == 8'h00) && (op_reg[7:6] != 2'b11)
                && !is_ccb;
  wire to_ea  = opm[2];

  // addressing mode legality classes
  wire ext_ok  = (ea_mode != `IOD_MODE_EXT) || (ea_reg <= `IOD_REG_IMM);
  wire src_ok  = (ea_mode != `IOD_MODE_AREG) && ext_ok;
  wire mem_alt = (ea_mode >= `IOD_MODE_IND) && ((ea_mode != `IOD_MODE_EXT)
                 || (ea_reg <= `IOD_REG_ABSL));
  wire dat_alt = (ea_mode == `IOD_MODE_DREG) || mem_alt;
  wire legal   = is_ccb | (is_imm & dat_alt)
                 | (is_or & (to_ea ? mem_alt : src_ok));
  wire src_imm = (ea_mode == `IOD_MODE_EXT) && (ea_reg == `IOD_REG_IMM);
  wire need_imm = is_ccb | is_imm | (is_or & !to_ea & src_imm);

  // operand size
  wire [1:0] size = is_or ? opm[1:0] : (is_ccb ? 2'b00 : op_reg[7:6]);
  wire       sz_b = (size == iod_pkg::SZ_BYTE);
  wire       sz_w = (size == iod_pkg::SZ_WORD);
  wire       sz_l = (size == iod_pkg::SZ_LONG);

  // operand routing
  wire        to_dreg = is_or & !to_ea;
  wire        dst_dr  = to_dreg | (is_imm & (ea_mode == `IOD_MODE_DREG));
  wire [2:0]  dst_idx = to_dreg ? reg_sel : ea_reg;
  wire [31:0] ea_val  = (ea_mode == `IOD_MODE_DREG) ? dreg_reg[ea_reg] : eaop_reg;
  wire [31:0] dst_val = dst_dr ? dreg_reg[dst_idx] : eaop_reg;
  wire [31:0] src_val = need_imm ? imm_reg :
                        (to_ea ? dreg_reg[reg_sel] : ea_val);
  wire [31:0] raw     = dst_val | src_val;

  // sized merge keeps untouched upper bits of the destination
  wire [31:0] res_full = sz_b ? {dst_val[31:8], raw[7:0]} :
                         sz_w ? {dst_val[31:16], raw[15:0]} : raw;
  wire        res_neg  = sz_b ? raw[7] : (sz_w ? raw[15] : raw[31]);
  wire        res_zero = sz_b ? (raw[7:0] == 8'h00) :
                         sz_w ? (raw[15:0] == 16'h0000) : (raw == 32'h0);
  wire        ccb_bad  = is_ccb & (imm_reg[15:8] != 8'h00);
  wire        exec_go  = (state_reg == iod_pkg::ST_EXEC) & !ccb_bad;
  wire        exec_alu = exec_go & !is_ccb;
  wire        exec_ccb = exec_go & is_ccb;
  wire        dec_bad  = (state_reg == iod_pkg::ST_DEC) & !legal;
  wire        set_ill  = dec_bad | ((state_reg == iod_pkg::ST_EXEC) & ccb_bad);
  wire        word_ok  = wr_instr & ((state_reg == iod_pkg::ST_IDLE)
                         | (state_reg == iod_pkg::ST_EXT1)
                         | (state_reg == iod_pkg::ST_EXT2));

  // sequencer: opcode, extension words, execute
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      iod_pkg::ST_IDLE: begin
        if (wr_instr) begin
          state_next = iod_pkg::ST_DEC;
        end
      end
      iod_pkg::ST_DEC: begin
        if (!legal) begin
          state_next = iod_pkg::ST_IDLE;
        end else if (need_imm) begin
          state_next = iod_pkg::ST_EXT1;
        end else begin
          state_next = iod_pkg::ST_EXEC;
        end
      end
      iod_pkg::ST_EXT1: begin
        if (wr_instr) begin
          state_next = sz_l ? iod_pkg::ST_EXT2 : iod_pkg::ST_EXEC;
        end
      end
      iod_pkg::ST_EXT2: begin
        if (wr_instr) begin
          state_next = iod_pkg::ST_EXEC;
        end
      end
      iod_pkg::ST_EXEC: state_next = iod_pkg::ST_IDLE;
      default:          state_next = iod_pkg::ST_IDLE;
    endcase
  end

  // state and opcode capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= iod_pkg::ST_IDLE;
      op_reg    <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (wr_instr && (state_reg == iod_pkg::ST_IDLE)) begin
        op_reg <= word_in;
      end
    end
  end

  // immediate assembly from extension words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imm_reg <= 32'h0;
    end else if (wr_instr && (state_reg == iod_pkg::ST_EXT1)) begin
      if (sz_l) begin
        imm_reg <= {word_in, 16'h0000};
      end else if (sz_b && !is_ccb) begin
        imm_reg <= {24'h0, word_in[7:0]};
      end else begin
        imm_reg <= {16'h0, word_in};
      end
    end else if (wr_instr && (state_reg == iod_pkg::ST_EXT2)) begin
      imm_reg <= {imm_reg[31:16], word_in};
    end
  end

  // condition code byte: execute wins over a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccb_reg <= `IOD_CCB_RST;
    end else if (exec_alu) begin
      ccb_reg <= {ccb_reg[`IOD_CCB_X], res_neg, res_zero, 2'b00};
    end else if (exec_ccb) begin
      ccb_reg <= ccb_reg | imm_reg[4:0];
    end else if (wr_ccb) begin
      ccb_reg <= pwdata[4:0];
    end
  end

  // memory operand stand-in and last result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eaop_reg   <= 32'h0;
      result_reg <= 32'h0;
    end else begin
      if (exec_alu && !dst_dr) begin
        eaop_reg <= res_full;
      end else if (wr_eaop) begin
        eaop_reg <= pwdata;
      end
      if (exec_alu) begin
        result_reg <= res_full;
      end
    end
  end

  // sticky status flags, a set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      illegal_reg <= 1'b0;
      done_reg    <= 1'b0;
    end else begin
      illegal_reg <= set_ill | (illegal_reg & ~(wr_status & pwdata[`IOD_ST_ILLEGAL]));
      done_reg    <= exec_go | (done_reg & ~(wr_status & pwdata[`IOD_ST_DONE]));
    end
  end

  // eight data registers
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_dreg
      wire hw_wr = exec_alu & dst_dr & (dst_idx == 3'(gi));
      wire sw_wr = wr_dreg & (bus_didx == 3'(gi));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dreg_reg[gi] <= 32'h0;
        end else if (hw_wr) begin
          dreg_reg[gi] <= res_full;
        end else if (sw_wr) begin
          dreg_reg[gi] <= pwdata;
        end
      end
    end
  endgenerate

  // read data selection
  wire [31:0] status_val = {29'h0, done_reg, illegal_reg,
                            state_reg != iod_pkg::ST_IDLE};
  wire [31:0] rd_mux = hit_dreg                   ? dreg_reg[bus_didx] :
                       (paddr == `IOD_OFF_INSTR)  ? {16'h0, op_reg} :
                       (paddr == `IOD_OFF_STATUS) ? status_val :
                       (paddr == `IOD_OFF_CCB)    ? {27'h0, ccb_reg} :
                       (paddr == `IOD_OFF_EAOP)   ? eaop_reg :
                       (paddr == `IOD_OFF_RESULT) ? result_reg : 32'h0;

  // apb answer: one wait state, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~hit;
      if (acc_first) begin
        prdata <= pwrite ? 32'h0 : rd_mux;
      end
    end
  end

  // checks
  a_vc_cleared: assert property (@(posedge pclk) disable iff (!presetn)
    exec_alu |=> (ccb_reg[1:0] == 2'b00))
    else $error("v or c not cleared after or");
  a_x_kept: assert property (@(posedge pclk) disable iff (!presetn)
    exec_alu |=> (ccb_reg[4] == $past(ccb_reg[4])))
    else $error("extend flag changed by or");
  a_nz_follow: assert property (@(posedge pclk) disable iff (!presetn)
    exec_alu |=> (ccb_reg[3:2] == $past({res_neg, res_zero})))
    else $error("n or z wrong after or");
  a_ccb_or: assert property (@(posedge pclk) disable iff (!presetn)
    exec_ccb |=> (ccb_reg == ($past(ccb_reg) | $past(imm_reg[4:0]))))
    else $error("condition byte or wrong");
  a_areg_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && (is_or || is_imm) && (ea_mode == `IOD_MODE_AREG))
    |=> (illegal_reg && (state_reg == iod_pkg::ST_IDLE)))
    else $error("address register operand accepted");
  a_dreg_dest_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_or && to_ea && (ea_mode == `IOD_MODE_DREG))
    |=> illegal_reg)
    else $error("data register ea destination accepted");
  a_pc_dest_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_imm && (ea_mode == `IOD_MODE_EXT)
     && (ea_reg > `IOD_REG_ABSL)) |=> (state_reg == iod_pkg::ST_IDLE))
    else $error("pc relative or immediate destination accepted");
  a_long_two_words: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_EXT1) && wr_instr && sz_l)
    |=> (state_reg == iod_pkg::ST_EXT2) ##1 (imm_reg[31:16] == $past(word_in, 2)))
    else $error("long immediate not two words");
  a_dreg_writeback: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_alu && to_dreg && sz_w)
    |=> (dreg_reg[$past(reg_sel)][15:0] == $past(raw[15:0])))
    else $error("data register not written back");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready held more than one cycle");

  // sequencing, fetch and refusal checks
  a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr without pready");
  a_exec_done: assert property (@(posedge pclk) disable iff (!presetn)
    exec_go |=> done_reg)
    else $error("done not flagged after execute");
  a_imm_awaited: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && legal && need_imm)
    |=> (state_reg == iod_pkg::ST_EXT1))
    else $error("immediate word not awaited");
  a_short_one_word: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_EXT1) && wr_instr && !sz_l)
    |=> (state_reg == iod_pkg::ST_EXEC))
    else $error("byte or word immediate not one word");
  a_byte_low_half: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_EXT1) && wr_instr && sz_b && !is_ccb)
    |=> (imm_reg == {24'h00_0000, $past(word_in[7:0])}))
    else $error("byte immediate not the low half");
  a_mem_dest_or: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_alu && is_or && to_ea && sz_l)
    |=> (eaop_reg == $past(dreg_reg[reg_sel] | eaop_reg)))
    else $error("memory operand not or-ed with data register");
  a_ccb_word_bad: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_EXEC) && ccb_bad)
    |=> (illegal_reg && (ccb_reg == $past(ccb_reg))))
    else $error("bad condition byte word accepted");
  a_size_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && (op_reg[15:8] == 8'h00) && (op_reg[7:6] == 2'b11))
    |=> illegal_reg)
    else $error("or-immediate size 11 accepted");
  a_src_ext_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_or && !to_ea && (ea_mode == `IOD_MODE_EXT)
     && (ea_reg > `IOD_REG_IMM)) |=> illegal_reg)
    else $error("unlisted source mode accepted");
  a_pc_mem_refused: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_or && to_ea && (ea_mode == `IOD_MODE_EXT)
     && (ea_reg > `IOD_REG_ABSL)) |=> illegal_reg)
    else $error("pc relative or immediate memory destination accepted");
  a_imm_dreg_dest: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_imm && (ea_mode == `IOD_MODE_DREG))
    |=> (state_reg == iod_pkg::ST_EXT1))
    else $error("data register destination of or-immediate refused");
  a_dreg_src_taken: assert property (@(posedge pclk) disable iff (!presetn)
    ((state_reg == iod_pkg::ST_DEC) && is_or && !to_ea && (ea_mode == `IOD_MODE_DREG))
    |=> (state_reg == iod_pkg::ST_EXEC))
    else $error("data register source refused");
endmodule

// *** bench/iod_prog_mem.sv ***
// program memory model handing out instruction words in order
`timescale 1ns/1ps
module iod_prog_mem (
  input  wire logic        pclk,  // bench clock
  input  wire logic        take,  // consume the head word
  output logic      [15:0] word,  // head word, scrambled once drained
  output logic             avail  // words still pending
);
  logic [15:0] q[$];
  logic [15:0] last;

  // refresh the head; a drained memory shows the inverse of the last word
  function automatic void show();
    avail = q.size() > 0;
    word  = avail ? q[0] : ~last;
  endfunction

  // words leave in program order, long data high word first
  task automatic load(input logic [15:0] w);
    q.push_back(w);
    show();
  endtask

  // pop the head word on a take strobe
  always @(posedge pclk) begin
    if (take && q.size() > 0) begin
      last = q.pop_front();
      show();
    end
  end

  // empty at start
  initial begin
    last = 16'h0000;
    show();
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the inclusive-or decoder
`timescale 1ns/1ps
`include "iod_regs.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, take, avail, er;
  logic [7:0]  paddr;
  logic [15:0] word, q[$];
  logic [15:0] bad[15] = '{16'h8008, 16'h803d, 16'h8100, 16'h8108, 16'h813a, 16'h813b,
                           16'h813c, 16'h0008, 16'h003a, 16'h003b, 16'h00bc, 16'h80c0,
                           16'h81c0, 16'h00c0, 16'h007c};
  logic [31:0] pwdata, prdata, rd, eaop_m, res_m, dreg_m[8];
  logic [4:0]  ccb_m;
  int          errors, total_checks, seed;

  iod_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  iod_prog_mem u_mem (.pclk(pclk), .take(take), .word(word), .avail(avail));

  // clock
  always #5 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, request held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) errors++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // model of the sized or with its flags
  function automatic logic [31:0] orv(input int sz, input logic [31:0] s, input logic [31:0] d);
    logic [31:0] m, r;
    m = sz == 0 ? 32'h0000_00ff : sz == 1 ? 32'h0000_ffff : 32'hffff_ffff;
    r = (d & ~m) | ((s | d) & m);
    ccb_m = {ccb_m[4], r[sz == 0 ? 7 : sz == 1 ? 15 : 31], (r & m) == 0, 2'b00};
    res_m = r;
    return r;
  endfunction

  task automatic newccb;
    logic [31:0] c;
    c = $random(seed);
    wr(`IOD_OFF_CCB, c);
    ccb_m = c[4:0];
  endtask

  // append immediate words; a byte carries junk in its upper half
  task automatic imm(input int sz, input logic [31:0] v, input logic [31:0] r);
    if (sz == 2) q.push_back(v[31:16]);
    q.push_back(sz == 0 ? {r[31:24], v[7:0]} : v[15:0]);
  endtask

  // compare all data registers, memory operand and flags with the model
  task automatic verify;
    for (int i = 0; i < 8; i++) rdc("dreg", 8'(`IOD_OFF_DREG + 4 * i), dreg_m[i]);
    rdc("eaop", `IOD_OFF_EAOP, eaop_m);
    rdc("ccb", `IOD_OFF_CCB, {27'h0, ccb_m});
    rdc("result", `IOD_OFF_RESULT, res_m);
  endtask

  // feed q through program memory, await the end, clear status, compare
  task automatic exec(input logic ill);
    logic [15:0] w;
    int n;
    foreach (q[i]) u_mem.load(q[i]);
    while (avail === 1'b1) begin
      w = word;
      take <= 1'b1;
      @(posedge pclk);
      take <= 1'b0;
      wr(`IOD_OFF_INSTR, {16'h0, w});
    end
    n = 0;
    rd = 0;
    while (rd[2:1] == 2'b00 && n < 10) begin
      apb(1'b0, `IOD_OFF_STATUS, 32'h0);
      n++;
    end
    chk("ended", 1, {31'h0, |rd[2:1]});
    chk("illegal", {31'h0, ill}, {31'h0, rd[1]});
    wr(`IOD_OFF_STATUS, 32'h6);
    rdc("status", `IOD_OFF_STATUS, 32'h0);
    rdc("opcode", `IOD_OFF_INSTR, {16'h0, q[0]});
    verify();
  endtask

  task automatic summarize;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence
  initial begin
    logic [31:0] r, v;
    logic [2:0]  md, rg, rn;
    {pclk, presetn, psel, penable, pwrite, take} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 81;
    dreg_m = '{default: 32'h0};
    eaop_m = 32'h0;
    res_m = 32'h0;
    ccb_m = 5'h00;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    verify();
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 1, {31'h0, er});
    chk("unmapped", 0, rd);
    for (int i = 0; i < 8; i++) begin
      dreg_m[i] = $random(seed);
      wr(8'(`IOD_OFF_DREG + 4 * i), dreg_m[i]);
    end
    eaop_m = $random(seed);
    wr(`IOD_OFF_EAOP, eaop_m);
    $display("test reset and registers done");
    // every source mode, every size, into a data register
    for (int sz = 0; sz < 3; sz++) begin
      for (int i = 0; i < 11; i++) begin
        r = $random(seed);
        v = $random(seed);
        md = i == 0 ? 3'h0 : i < 6 ? 3'(i + 1) : 3'h7;
        rg = i < 6 ? r[5:3] : 3'(i - 6);
        rn = r[8:6];
        newccb();
        q = {{4'h8, rn, 1'b0, 2'(sz), md, rg}};
        if (i == 10) imm(sz, v, r);
        dreg_m[rn] = orv(sz, md == 0 ? dreg_m[rg] : i == 10 ? v : eaop_m, dreg_m[rn]);
        exec(1'b0);
      end
    end
    // data register into every memory alterable destination
    for (int sz = 0; sz < 3; sz++) begin
      for (int i = 0; i < 7; i++) begin
        r = $random(seed);
        md = i < 5 ? 3'(i + 2) : 3'h7;
        rg = i < 5 ? r[5:3] : 3'(i - 5);
        rn = r[8:6];
        newccb();
        q = {{4'h8, rn, 1'b1, 2'(sz), md, rg}};
        eaop_m = orv(sz, dreg_m[rn], eaop_m);
        exec(1'b0);
      end
    end
    $display("test register or done");
    // immediate into every data alterable destination
    for (int sz = 0; sz < 3; sz++) begin
      for (int i = 0; i < 8; i++) begin
        r = $random(seed);
        v = $random(seed);
        md = i == 0 ? 3'h0 : i < 6 ? 3'(i + 1) : 3'h7;
        rg = i < 6 ? r[5:3] : 3'(i - 6);
        newccb();
        q = {{8'h00, 2'(sz), md, rg}};
        imm(sz, v, r);
        if (md == 3'h0) dreg_m[rg] = orv(sz, v, dreg_m[rg]);
        else eaop_m = orv(sz, v, eaop_m);
        exec(1'b0);
      end
    end
    // all-zero result
    dreg_m[0] = 32'h0;
    eaop_m = 32'h0;
    wr(`IOD_OFF_DREG, 32'h0);
    wr(`IOD_OFF_EAOP, 32'h0);
    newccb();
    q = {16'h8090};
    dreg_m[0] = orv(2, 32'h0, 32'h0);
    exec(1'b0);
    $display("test immediate done");
    // each flag bit once, bits 7 to 5 ignored, a nonzero upper byte refused
    for (int k = 0; k < 5; k++) begin
      v = $random(seed) & 32'he0 | 32'h1 << k;
      newccb();
      q = {16'h003c, v[15:0]};
      ccb_m = ccb_m | v[4:0];
      exec(1'b0);
    end
    newccb();
    q = {16'h003c, 16'h5a0f};
    exec(1'b1);
    $display("test condition byte done");
    // refused encodings leave data registers, memory operand, result and condition byte untouched
    foreach (bad[i]) begin
      newccb();
      q = {bad[i]};
      exec(1'b1);
    end
    $display("test refusals done");
    // reset in mid-run brings every register back to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    dreg_m = '{default: 32'h0};
    eaop_m = 32'h0;
    res_m = 32'h0;
    ccb_m = 5'h00;
    verify();
    rdc("status", `IOD_OFF_STATUS, 32'h0);
    rdc("opcode", `IOD_OFF_INSTR, 32'h0);
    $display("test mid-run reset done");
    summarize();
  end

  // watchdog
  initial begin
    #400000;
    errors++;
    summarize();
  end
endmodule
